/* logic/tai_pkg.sv */
// Shared constants and types for the touch converter serial link.
package tai_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int SCL_NS = 160;
  localparam logic [2:0] QTR_LAST = 3'(SCL_NS / CLK_NS / 4 - 1);
  localparam int WAIT_NS = 10000;
  localparam int WAIT_CYC = (WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [8:0] WAIT_LAST = 9'(WAIT_CYC - 1);
  localparam int CCLK12_NS = 500;
  localparam int CCLK8_NS = 250;
  localparam logic [4:0] DIV12_LAST = 5'(CCLK12_NS / CLK_NS - 1);
  localparam logic [4:0] DIV8_LAST = 5'(CCLK8_NS / CLK_NS - 1);
  localparam int SAMP12 = 19;
  localparam int SAMP8 = 16;
  localparam int FILT_CYC = 19;
  localparam int NSAMP = 7;
  localparam logic [4:0] SAMP12_LAST = 5'(SAMP12 - 1);
  localparam logic [4:0] SAMP8_LAST = 5'(SAMP8 - 1);
  localparam logic [4:0] FILT_LAST = 5'(FILT_CYC - 1);
  localparam logic [4:0] OVERLAP = 5'h04;
  localparam logic [2:0] SIDX_LAST = 3'(NSAMP - 1);

  // ****************************************
  // Frame layout
  // ****************************************
  localparam logic [5:0] ADDR_PREFIX = 6'h24;
  localparam logic [7:0] INVALID_BYTE = 8'hFF;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] FSEL_BITS = 4'h4;
  localparam int M_BIT = 1;
  localparam int RES_W = 12;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [3:0] {
    D_IDLE = 4'h0, D_ADDR = 4'h1, D_AACK = 4'h2, D_CMD = 4'h3,
    D_CACK = 4'h4, D_IGN = 4'h5, D_TX = 4'h6, D_TACK = 4'h7,
    D_TNEXT = 4'h8, D_DONE = 4'h9
  } tai_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_START = 3'h1, H_BIT = 3'h2, H_STOP = 3'h3,
    H_WAIT = 3'h4
  } tai_hst_t;

endpackage : tai_pkg

/* logic/tai_if.sv */
// Two-wire link between the bus master and the touch converter.
`timescale 1ns/100ps
interface tai_if;
  logic scl;
  logic sda;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;

  // A released line reads high, as with the external pull-up.
  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport device (
    input scl,
    input sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );

  modport host (
    output scl,
    input sda,
    output host_sda_out,
    output host_sda_oe_n
  );
endinterface : tai_if

/* logic/tai_fifo.sv */
// Result FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module tai_fifo
  import tai_pkg::*;
#(
  parameter int WIDTH = RES_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic nempty;
  } tai_fifo_s_t;

  tai_fifo_s_t s;
  tai_fifo_s_t n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr;
  logic rd;

  assign wr = in_valid & ~s.full;
  assign rd = out_ready & s.nempty;
  assign in_ready = ~s.full;
  assign out_valid = s.nempty;
  assign out_data = mem[s.rp];

  always_comb begin
    n = s;
    if (wr) n.wp = s.wp + 1'b1;
    if (rd) n.rp = s.rp + 1'b1;
    n.cnt = s.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    n.full = n.cnt == (AW+1)'(DEPTH);
    n.nempty = n.cnt != '0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
    if (wr) mem[s.wp] <= in_data;
  end
endmodule : tai_fifo

/* logic/tai_device.sv */
// Converter end: serial slave, acquisition timing and result filter.
`timescale 1ns/100ps
module tai_device
  import tai_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial link
  tai_if.device bus,
  // Converter side
  input wire logic addr_select_pin,
  input wire logic [11:0] adc_sample,
  output logic [3:0] mux_channel,
  output logic mux_enable,
  output logic x_drivers,
  output logic y_drivers,
  output logic acquiring,
  output logic converting,
  output logic [11:0] result
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    tai_dst_t st;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic ap1;
    logic ap2;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic rd;
    logic eight;
    logic [3:0] mux;
    logic muxen;
    logic xdrv;
    logic ydrv;
    logic acq;
    logic conv;
    logic filt;
    logic [4:0] div;
    logic [4:0] tcnt;
    logic [2:0] sidx;
    logic [14:0] acc;
    logic [11:0] res;
    logic [7:0] tx;
    logic [1:0] tidx;
    logic sda_o;
    logic sda_oe_n;
  } tai_dev_s_t;

  tai_dev_s_t s;
  tai_dev_s_t n;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic tick;
  logic [4:0] slen;
  logic [14:0] smp;

  // Byte sent at each read position; anything past the last is invalid.
  function automatic logic [7:0] tx_byte(logic [1:0] idx, logic [11:0] r,
                                         logic e);
    logic [7:0] b;
    b = INVALID_BYTE;
    if (idx == 2'h0) begin
      b = r[11:4];
    end else if (idx == 2'h1 && !e) begin
      b = {r[3:0], 4'h0};
    end
    return b;
  endfunction : tx_byte

  // ****************************************
  // Link edge and condition detection
  // ****************************************
  // Only the second synchroniser stage and its delayed copy are looked at.
  assign rise = s.scl2 & ~s.scl3;
  assign fall = ~s.scl2 & s.scl3;
  assign start = s.scl2 & s.scl3 & s.sda3 & ~s.sda2;
  assign stop = s.scl2 & s.scl3 & ~s.sda3 & s.sda2;
  assign tick = s.div == (s.eight ? DIV8_LAST : DIV12_LAST);
  assign slen = s.eight ? SAMP8_LAST : SAMP12_LAST;
  assign smp = {3'h0, adc_sample};

  always_comb begin
    logic ld;
    logic [7:0] b;
    ld = 1'b0;
    b = 8'h00;
    n = s;
    n.scl1 = bus.scl;
    n.scl2 = s.scl1;
    n.scl3 = s.scl2;
    n.sda1 = bus.sda;
    n.sda2 = s.sda1;
    n.sda3 = s.sda2;
    n.ap1 = addr_select_pin;
    n.ap2 = s.ap1;

    // ****************************************
    // Conversion sequencer
    // ****************************************
    if (s.conv) begin
      n.div = tick ? 5'h00 : s.div + 5'h01;
      if (tick) begin
        n.tcnt = s.tcnt + 5'h01;
        if (!s.filt && s.tcnt == slen) begin
          n.tcnt = 5'h00;
          n.sidx = s.sidx + 3'h1;
          // The overlapped first sample is counted twice so eight sum.
          n.acc = s.acc + smp + (s.sidx == 3'h0 ? smp : 15'h0000);
          if (s.sidx == SIDX_LAST) n.filt = 1'b1;
        end else if (s.filt && s.tcnt == FILT_LAST) begin
          n.res = s.eight ? {s.acc[14:7], 4'h0} : s.acc[14:3];
          n.conv = 1'b0;
          n.xdrv = 1'b0;
          n.ydrv = 1'b0;
        end
      end
    end

    // ****************************************
    // Serial slave
    // ****************************************
    if (start || stop) begin
      n.bcnt = 4'h0;
      n.sda_oe_n = 1'b1;
      n.st = start ? D_ADDR : D_IDLE;
      if (s.acq) begin
        n.acq = 1'b0;
        n.conv = 1'b1;
        n.muxen = 1'b0;
        n.tcnt = OVERLAP;
        n.div = 5'h00;
        n.sidx = 3'h0;
        n.acc = 15'h0000;
        n.filt = 1'b0;
      end
    end else begin
      unique case (s.st)
        D_IDLE, D_IGN, D_DONE: begin
          // Extra command bytes are clocked past and never acked.
          n.sda_oe_n = 1'b1;
        end
        D_ADDR: begin
          if (rise) begin
            n.sh = {s.sh[6:0], s.sda2};
            n.bcnt = s.bcnt + 4'h1;
          end
          if (fall && s.bcnt == BYTE_BITS) begin
            n.st = D_IDLE;
            if (s.sh[7:1] == {ADDR_PREFIX, s.ap2}) begin
              n.rd = s.sh[0];
              n.sda_oe_n = 1'b0;
              n.st = D_AACK;
            end
          end
        end
        D_AACK: begin
          if (fall) begin
            n.bcnt = 4'h0;
            n.sda_oe_n = 1'b1;
            n.st = D_CMD;
            if (s.rd) begin
              n.tidx = 2'h0;
              ld = 1'b1;
            end
          end
        end
        D_CMD: begin
          if (rise) begin
            n.sh = {s.sh[6:0], s.sda2};
            n.bcnt = s.bcnt + 4'h1;
            if (s.bcnt < FSEL_BITS) n.mux = {s.mux[2:0], s.sda2};
          end
          if (fall && s.bcnt == FSEL_BITS) begin
            n.acq = 1'b1;
            n.conv = 1'b0;
            n.muxen = 1'b1;
            n.xdrv = s.sh[3] & s.sh[2] & (s.sh[1] | ~s.sh[0]);
            n.ydrv = s.sh[3] & s.sh[2] & (s.sh[1] | s.sh[0]);
          end
          if (fall && s.bcnt == BYTE_BITS) begin
            n.eight = s.sh[M_BIT];
            n.sda_oe_n = 1'b0;
            n.st = D_CACK;
          end
        end
        D_CACK: begin
          if (fall) begin
            n.sda_oe_n = 1'b1;
            n.st = D_IGN;
          end
        end
        D_TX: begin
          if (fall) begin
            if (s.bcnt == BYTE_BITS) begin
              n.sda_oe_n = 1'b1;
              n.st = D_TACK;
            end else begin
              n.sda_oe_n = s.tx[7];
              n.tx = {s.tx[6:0], 1'b0};
              n.bcnt = s.bcnt + 4'h1;
            end
          end
        end
        D_TACK: begin
          if (rise) begin
            if (!s.sda2) begin
              n.tidx = (s.tidx == 2'h2) ? 2'h2 : s.tidx + 2'h1;
              n.st = D_TNEXT;
            end else begin
              n.st = D_DONE;
            end
          end
        end
        D_TNEXT: begin
          if (fall) ld = 1'b1;
        end
        default: begin
          n.st = D_IDLE;
        end
      endcase
    end

    // Loading a byte drives its first bit on the same falling edge.
    if (ld) begin
      b = tx_byte(n.tidx, s.res, s.eight);
      n.sda_oe_n = b[7];
      n.tx = {b[6:0], 1'b0};
      n.bcnt = 4'h1;
      n.st = D_TX;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.scl1 <= 1'b1;
      s.scl2 <= 1'b1;
      s.scl3 <= 1'b1;
      s.sda1 <= 1'b1;
      s.sda2 <= 1'b1;
      s.sda3 <= 1'b1;
      s.sda_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bus.dev_sda_out = s.sda_o;
  assign bus.dev_sda_oe_n = s.sda_oe_n;
  assign mux_channel = s.mux;
  assign mux_enable = s.muxen;
  assign x_drivers = s.xdrv;
  assign y_drivers = s.ydrv;
  assign acquiring = s.acq;
  assign converting = s.conv;
  assign result = s.res;
endmodule : tai_device

/* logic/tai_host.sv */
// Master end: writes commands, reads results into a FIFO.
`timescale 1ns/100ps
module tai_host
  import tai_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Serial link
  tai_if.host bus,
  // Command port
  input wire logic addr_select_pin,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_byte,
  // Result port
  output logic res_valid,
  input wire logic res_ready,
  output logic [11:0] res_data,
  // Status
  output logic addr_nack
);

  typedef struct packed {
    tai_hst_t st;
    logic sda1;
    logic sda2;
    logic ap1;
    logic ap2;
    logic [2:0] qc;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [1:0] bidx;
    logic [7:0] sh;
    logic [7:0] cmd;
    logic [7:0] b1;
    logic rd;
    logic eight;
    logic scl;
    logic sda_o;
    logic oe_n;
    logic [8:0] wcnt;
    logic push;
    logic [11:0] res;
    logic nack;
    logic rdy;
  } tai_host_s_t;

  tai_host_s_t s;
  tai_host_s_t n;
  logic qend;
  logic rxb;
  logic last;
  logic fifo_in_ready;

  assign qend = s.qc == QTR_LAST;
  assign rxb = s.rd && s.bidx != 2'h0;
  // An 8-bit read takes one data byte, a 12-bit read two.
  assign last = s.bidx == (s.eight ? 2'h1 : 2'h2);

  // ****************************************
  // Bit sequencer, four quarters per bit
  // ****************************************
  always_comb begin
    n = s;
    n.sda1 = bus.sda;
    n.sda2 = s.sda1;
    n.ap1 = addr_select_pin;
    n.ap2 = s.ap1;
    n.push = 1'b0;
    n.qc = qend ? 3'h0 : s.qc + 3'h1;
    if (qend) n.q = s.q + 2'h1;
    unique case (s.st)
      H_IDLE: begin
        if (cmd_valid && s.rdy) begin
          n.rd = cmd_read;
          n.cmd = cmd_byte;
          n.sh = {ADDR_PREFIX, s.ap2, cmd_read};
          if (!cmd_read) n.eight = cmd_byte[M_BIT];
          n.bidx = 2'h0;
          n.bitn = 4'h0;
          n.nack = 1'b0;
          n.qc = 3'h0;
          n.q = 2'h0;
          n.st = H_START;
        end
      end
      H_START: begin
        if (qend && s.q == 2'h0) n.oe_n = 1'b0;
        if (qend && s.q == 2'h1) begin
          n.scl = 1'b0;
          n.q = 2'h0;
          n.st = H_BIT;
        end
      end
      H_BIT: begin
        if (qend && s.q == 2'h0) begin
          // Ack slot of a read byte: ack unless it is the last one.
          n.oe_n = s.bitn[3] ? (!rxb | last) : (rxb | s.sh[7]);
        end
        if (qend && s.q == 2'h1) n.scl = 1'b1;
        if (qend && s.q == 2'h3) begin
          n.scl = 1'b0;
          n.bitn = s.bitn + 4'h1;
          if (!s.bitn[3]) begin
            n.sh = {s.sh[6:0], s.sda2};
          end else begin
            n.bitn = 4'h0;
            if (rxb) begin
              if (s.bidx == 2'h1) n.b1 = s.sh;
              if (last) n.st = H_STOP;
              else n.bidx = s.bidx + 2'h1;
            end else if (s.sda2) begin
              n.nack = 1'b1;
              n.st = H_STOP;
            end else if (s.rd) begin
              n.bidx = 2'h1;
            end else if (s.bidx == 2'h0) begin
              n.sh = s.cmd;
              n.bidx = 2'h1;
            end else begin
              n.st = H_STOP;
            end
          end
        end
      end
      H_STOP: begin
        if (qend && s.q == 2'h0) n.oe_n = 1'b0;
        if (qend && s.q == 2'h1) n.scl = 1'b1;
        if (qend && s.q == 2'h2) n.oe_n = 1'b1;
        if (qend && s.q == 2'h3) begin
          n.wcnt = 9'h000;
          n.st = s.rd ? H_IDLE : H_WAIT;
          if (s.rd && !s.nack) begin
            n.push = 1'b1;
            n.res = s.eight ? {s.b1, 4'h0} : {s.b1, s.sh[7:4]};
          end
        end
      end
      H_WAIT: begin
        // Keep the bus quiet for WAIT_CYC cycles (10 us) after a write, the start of the conversion.
        n.wcnt = s.wcnt + 9'h001;
        if (s.wcnt == WAIT_LAST) n.st = H_IDLE;
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
    // A read is only started when its result has room to land. The word
    // pushed last cycle is not yet in the full flag, so it blocks as well.
    n.rdy = (n.st == H_IDLE) && fifo_in_ready && !n.push && !s.push;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= '0;
      s.sda1 <= 1'b1;
      s.sda2 <= 1'b1;
      s.scl <= 1'b1;
      s.oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  tai_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(s.push),
    .in_ready(fifo_in_ready),
    .in_data(s.res),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  assign bus.scl = s.scl;
  assign bus.host_sda_out = s.sda_o;
  assign bus.host_sda_oe_n = s.oe_n;
  assign cmd_ready = s.rdy;
  assign addr_nack = s.nack;
endmodule : tai_host

/* testbench/tai_link_properties.sv */
// Link-level checker watching both ends of the touch converter link.
`timescale 1ns/100ps
module tai_link_chk
  import tai_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n
);
  typedef struct packed {
    logic s_scl;
    logic s_sda;
    logic [5:0] cnt;
    logic [7:0] sh;
    logic [7:0] abyte;
    logic acked;
    logic mbit;
    logic after_wr;
    logic [9:0] gap;
  } tai_chk_t;
  tai_chk_t q;
  tai_chk_t next_q;
  logic fall;
  logic start;
  logic stop;
  logic wr;
  logic rd;
  logic [5:0] nb;
  logic [5:0] last;

  // ****************************************
  // Frame tracking
  // ****************************************
  // Bits are taken at the SCL fall from the previous sample, because the
  // device only moves SDA a few cycles after that fall.
  always_comb begin
    fall = q.s_scl & ~scl;
    start = q.s_scl & scl & q.s_sda & ~sda;
    stop = q.s_scl & scl & ~q.s_sda & sda;
    nb = q.cnt + 6'h01;
    wr = q.acked & ~q.abyte[0];
    rd = q.acked & q.abyte[0];
    last = q.mbit ? 6'h12 : 6'h1B;
    next_q = q;
    next_q.s_scl = scl;
    next_q.s_sda = sda;
    if (q.gap != 10'h3FF) next_q.gap = q.gap + 10'h001;
    if (stop && wr) begin
      next_q.after_wr = 1'b1;
      next_q.gap = 10'h000;
    end
    if (start) begin
      next_q.cnt = 6'h3F;
      next_q.acked = 1'b0;
      next_q.after_wr = 1'b0;
    end
    if (fall) begin
      next_q.cnt = nb;
      next_q.sh = {q.sh[6:0], q.s_sda};
      if (nb == 6'h08) next_q.abyte = {q.sh[6:0], q.s_sda};
      if (nb == 6'h09) next_q.acked = ~q.s_sda;
      if (nb == 6'h10 && wr) next_q.mbit = q.s_sda;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) q <= '0;
    else q <= next_q;
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_ack_prefix;
    fall && nb == 6'h09 && !q.s_sda |-> q.abyte[7:2] == ADDR_PREFIX;
  endproperty
  a_ack_prefix: assert property (p_ack_prefix)
    else $error("address acked without prefix");
  property p_no_early_ack;
    fall && nb >= 6'h01 && nb <= 6'h08 |-> dev_sda_oe_n;
  endproperty
  a_no_early_ack: assert property (p_no_early_ack)
    else $error("device pulled sda inside address byte");
  property p_cmd_ack;
    fall && wr && nb == 6'h12 |-> !q.s_sda;
  endproperty
  a_cmd_ack: assert property (p_cmd_ack)
    else $error("command byte not acked");
  property p_write_len;
    stop && wr |-> q.cnt == 6'h12;
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write frame length wrong");
  property p_read_len;
    stop && rd |-> q.cnt == last;
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read frame length wrong");
  property p_master_nack;
    fall && rd && nb == last |-> q.s_sda;
  endproperty
  a_master_nack: assert property (p_master_nack)
    else $error("final byte not answered by not-acknowledge");
  property p_master_ack;
    fall && rd && !q.mbit && nb == 6'h12 |-> !q.s_sda && dev_sda_oe_n;
  endproperty
  a_master_ack: assert property (p_master_ack)
    else $error("first data byte ack slot wrong");
  property p_low_zero;
    fall && rd && !q.mbit && nb >= 6'h17 && nb <= 6'h1A |-> !q.s_sda;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("second byte tail not zero");
  property p_idle_wait;
    start && q.after_wr |-> q.gap >= 10'(WAIT_CYC);
  endproperty
  a_idle_wait: assert property (p_idle_wait)
    else $error("bus reused too soon after a write");
  property p_open_drain;
    !host_sda_out && !dev_sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda driven high instead of released");
endmodule : tai_link_chk

/* testbench/touch_adc_i2c_transaction_tb_top.sv */
// Bench joining host and device ends, plus a hand-driven fault link.
`timescale 1ns/100ps
module touch_adc_i2c_transaction_tb_top
  import tai_pkg::*;
();
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic host_sel = 1'b0;
  logic dev_sel = 1'b0;
  logic [11:0] adc = 12'hA5C;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_byte = 8'h00;
  logic res_ready = 1'b0;
  logic cmd_ready;
  logic res_valid;
  logic addr_nack;
  logic [11:0] res_data;
  logic [3:0] mux_channel;
  logic mux_enable;
  logic x_drv;
  logic y_drv;
  logic acq;
  logic conv;
  logic flt_conv;
  logic [11:0] result;
  int num_errors = 0;
  int checks = 0;
  tai_if link();
  tai_if flt();

  always #10 sys_clk = ~sys_clk;

  tai_host tai_host_i (
    .sys_clk(sys_clk), .rstn(rstn), .bus(link.host),
    .addr_select_pin(host_sel), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_byte(cmd_byte),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .addr_nack(addr_nack)
  );
  tai_device tai_device_i (
    .sys_clk(sys_clk), .rstn(rstn), .bus(link.device),
    .addr_select_pin(dev_sel), .adc_sample(adc),
    .mux_channel(mux_channel), .mux_enable(mux_enable),
    .x_drivers(x_drv), .y_drivers(y_drv), .acquiring(acq),
    .converting(conv), .result(result)
  );
  // The second device faces the bench, which breaks master rules on purpose.
  tai_device tai_device_i2 (
    .sys_clk(sys_clk), .rstn(rstn), .bus(flt.device),
    .addr_select_pin(1'b1), .adc_sample(adc), .mux_channel(),
    .mux_enable(), .x_drivers(), .y_drivers(), .acquiring(),
    .converting(flt_conv), .result()
  );
  tai_link_chk tai_link_chk_i (
    .sys_clk(sys_clk), .rstn(rstn), .scl(link.scl), .sda(link.sda),
    .host_sda_out(link.host_sda_out), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe_n(link.dev_sda_oe_n)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      chk("wait bound", 1'b0, 1'b1);
      end_of_test();
    end
  endtask : tmo

  task automatic idle_wait();
    int n;
    for (n = 0; n < 6000 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
    tmo(n, 6000);
  endtask : idle_wait

  task automatic send_cmd(input logic rd, input logic [7:0] b);
    idle_wait();
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_byte = b;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    @(negedge sys_clk);
  endtask : send_cmd

  // Half periods of four cycles give the 160 ns link clock.
  task automatic bb_bit(input logic b, output logic r);
    flt.host_sda_oe_n = b;
    repeat (2) @(negedge sys_clk);
    flt.scl = 1'b1;
    repeat (4) @(negedge sys_clk);
    r = flt.sda;
    flt.scl = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : bb_bit

  task automatic bb_byte(input logic [7:0] d, input logic ma,
                         output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bb_bit(d[i], r);
      q = {q[6:0], r};
    end
    bb_bit(ma, a);
  endtask : bb_byte

  // START lets sda fall while scl is high, STOP lets it rise.
  task automatic bb_edge(input logic stop);
    flt.host_sda_oe_n = ~stop;
    repeat (2) @(negedge sys_clk);
    flt.scl = 1'b1;
    repeat (4) @(negedge sys_clk);
    flt.host_sda_oe_n = stop;
    repeat (4) @(negedge sys_clk);
    flt.scl = stop;
    repeat (2) @(negedge sys_clk);
  endtask : bb_edge

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_convert(input logic [7:0] c, input logic [1:0] drv,
                           input int ticks, input int div,
                           input logic [11:0] exp);
    int n;
    send_cmd(1'b0, c);
    for (n = 0; n < 400 && acq !== 1'b1; n++) @(negedge sys_clk);
    tmo(n, 400);
    chk("channel", mux_channel, c[7:4]);
    chk("acq", {mux_enable, x_drv, y_drv}, {1'b1, drv});
    for (n = 0; n < 400 && acq !== 1'b0; n++) @(negedge sys_clk);
    tmo(n, 400);
    chk("conv", {conv, mux_enable, x_drv, y_drv}, {2'b10, drv});
    for (n = 0; n < 5000 && conv === 1'b1; n++) @(negedge sys_clk);
    tmo(n, 5000);
    chk("ticks", (n + div / 2) / div, ticks);
    chk("result", result, exp);
    chk("drv off", {x_drv, y_drv}, 2'b00);
    $display("conversion test done for command %h", c);
  endtask : t_convert

  task automatic t_read(input logic [11:0] exp);
    int n;
    send_cmd(1'b1, 8'h00);
    for (n = 0; n < 600 && res_valid !== 1'b1; n++) @(negedge sys_clk);
    tmo(n, 600);
    chk("res_data", res_data, exp);
    chk("addr_nack", addr_nack, 1'b0);
    res_ready = 1'b1;
    @(negedge sys_clk);
    res_ready = 1'b0;
    chk("popped", res_valid, 1'b0);
    $display("read test done");
  endtask : t_read

  task automatic t_addr();
    host_sel = 1'b1;
    repeat (4) @(negedge sys_clk);
    send_cmd(1'b1, 8'h00);
    idle_wait();
    chk("nack", {addr_nack, res_valid}, 2'b10);
    dev_sel = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_read(12'h3C0);
    host_sel = 1'b0;
    dev_sel = 1'b0;
    repeat (4) @(negedge sys_clk);
    $display("address select test done");
  endtask : t_addr

  task automatic t_fifo();
    logic rdy_seen;
    rdy_seen = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) send_cmd(1'b1, 8'h00);
    // A ready pulse as the last word lands would let a result be lost.
    repeat (400) begin
      @(negedge sys_clk);
      rdy_seen = rdy_seen | cmd_ready;
    end
    chk("full", {rdy_seen, res_valid}, 2'b01);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      chk("word", {res_valid, res_data}, {1'b1, 12'h3C0});
      res_ready = 1'b1;
      @(negedge sys_clk);
      res_ready = 1'b0;
      @(negedge sys_clk);
    end
    chk("drained", res_valid, 1'b0);
    $display("fifo test done");
  endtask : t_fifo

  task automatic t_fault();
    logic [7:0] q;
    logic a;
    int n;
    bb_edge(1'b0);
    bb_byte({ADDR_PREFIX, 2'b00}, 1'b1, q, a);
    chk("wrong addr", a, 1'b1);
    bb_edge(1'b1);
    bb_edge(1'b0);
    bb_byte({ADDR_PREFIX, 2'b10}, 1'b1, q, a);
    chk("addr ack", a, 1'b0);
    bb_byte(8'hC0, 1'b1, q, a);
    chk("cmd ack", a, 1'b0);
    bb_byte(8'hC0, 1'b1, q, a);
    chk("extra", a, 1'b1);
    bb_edge(1'b1);
    repeat (8) @(negedge sys_clk);
    for (n = 0; n < 5000 && flt_conv === 1'b1; n++) @(negedge sys_clk);
    tmo(n, 5000);
    bb_edge(1'b0);
    bb_byte({ADDR_PREFIX, 2'b11}, 1'b1, q, a);
    chk("rd ack", a, 1'b0);
    bb_byte(8'hFF, 1'b0, q, a);
    chk("byte1", q, adc[11:4]);
    bb_byte(8'hFF, 1'b0, q, a);
    chk("byte2", q, {adc[3:0], 4'h0});
    bb_byte(8'hFF, 1'b1, q, a);
    chk("byte3", q, INVALID_BYTE);
    bb_edge(1'b1);
    $display("fault link test done");
  endtask : t_fault

  initial begin
    flt.scl = 1'b1;
    flt.host_sda_oe_n = 1'b1;
    flt.host_sda_out = 1'b0;
    repeat (20) @(negedge sys_clk);
    rstn = 1'b1;
    t_convert(8'hC0, 2'b10, SAMP12 * NSAMP + FILT_CYC - 4, 25, 12'hA5C);
    t_read(12'hA5C);
    adc = 12'h3C7;
    t_convert(8'hE2, 2'b11, SAMP8 * NSAMP + FILT_CYC - 4, 12, 12'h3C0);
    t_read(12'h3C0);
    t_addr();
    t_fifo();
    t_fault();
    end_of_test();
  end
endmodule : touch_adc_i2c_transaction_tb_top
